// ---- include/dax_pkg.sv ----
// constants and carrier types of the dual converter control block.
// shared by the design top and by anything that drives or checks it.
package dax_pkg;
  // widths
  localparam int DATA_W = 16;
  localparam int CFG_W  = 12;
  localparam int TRIM_W = 9;
  localparam int CNT_W  = 6;

  // config_reg field positions
  localparam int MODE_SINGLE_POS  = 10;
  localparam int RANGE_DOUBLE_POS = 9;
  localparam int INPUT_TYPE_POS   = 7;
  localparam int REF_SOURCE_POS   = 6;
  localparam int CODE_FORMAT_POS  = 4;

  // reset values
  localparam logic [CFG_W-1:0]  CFG_RST  = 12'h000;
  localparam logic [TRIM_W-1:0] TRIM_RST = 9'h1FF;

  // link clock edge counts inside a frame
  localparam logic [CNT_W-1:0] EDGES_DUAL   = 6'h20;
  localparam logic [CNT_W-1:0] EDGES_SINGLE = 6'h30;
  localparam logic [CNT_W-1:0] CMD_EDGES    = 6'h10;
  localparam logic [CNT_W-1:0] MSB_EDGE     = 6'h10;
  localparam logic [CNT_W-1:0] TAKE_EDGE    = 6'h0F;

  // command codes in the top four bits of the command word
  localparam logic [3:0] CMD_RD_TRIM_A = 4'h1;
  localparam logic [3:0] CMD_RD_TRIM_B = 4'h2;
  localparam logic [3:0] CMD_RD_CFG    = 4'h3;
  localparam logic [3:0] CMD_WR_CFG    = 4'h8;
  localparam logic [3:0] CMD_WR_TRIM_A = 4'h9;
  localparam logic [3:0] CMD_WR_TRIM_B = 4'hA;

  // output codes
  localparam logic [DATA_W-1:0] ZERO_CODE  = 16'h0000;
  localparam logic [DATA_W-1:0] MID_CODE   = 16'h7FFF;
  localparam logic [DATA_W-1:0] FULL_CODE  = 16'hFFFF;
  localparam logic [DATA_W-1:0] NEG_FS     = 16'h8000;
  localparam logic [DATA_W-1:0] POS_FS     = 16'h7FFF;
  localparam logic [DATA_W-1:0] TC_MIDSCALE = 16'h0000;

  // per-frame setup handed from the system side to the link side
  typedef struct packed {
    logic              single;
    logic              rb_en;
    logic [DATA_W-1:0] rb_word;
    logic [CNT_W-1:0]  nedges;
  } dax_setup_type;
endpackage

// ---- design/dax_top.sv ----
// dual converter control: config bits, reference trims, output coding,
// framed serial link on its own clock and a small result buffer.
// assumes the link clock runs only inside frames, chip select stays high
// for at least 8 system clocks between frames, and the converter cores
// return straight-binary codes of (positive - negative input).
`timescale 1ns/1ps
// Notes on behaviour
// - ref bit clear: internal ref off, external pins
// - ref bit set: per-channel trims drive pins
// - one ref bit, bit six, both channels
// - range bit doubles full scale, both channels
// - input type clear: single-ended, negatives grounded
// - input type set: pseudo-differential, both channels
// - format bit picks binary or twos complement
// - straight binary zero, mid, full codes
// - twos complement negative, mid, positive codes
// - sixteen-bit result, step is range/65536
// - both channels sampled together, differential
// - top command nibble selects read/write/nop
// - writes apply at frame end if enough edges
module dax_top #(
  parameter int DEPTH = 2,
  parameter int DW    = dax_pkg::DATA_W
) (
  // system clock and reset
  input  wire logic                        i_clock,
  input  wire logic                        i_sys_rst,
  // serial link
  input  wire logic                        i_link_clk,
  input  wire logic                        i_cs_n,
  input  wire logic                        i_serial_cmd_in,
  output logic                             o_serial_out_a,
  output logic                             o_serial_out_a_oe_n,
  output logic                             o_serial_out_b,
  output logic                             o_serial_out_b_oe_n,
  // converter cores
  output logic                             o_sample,
  input  wire logic                        i_conv_valid,
  input  wire logic [DW-1:0]               i_conv_a,
  input  wire logic [DW-1:0]               i_conv_b,
  output logic                             o_conv_ready,
  // analog configuration
  output logic                             o_int_ref_on,
  output logic [dax_pkg::TRIM_W-1:0]       o_ref_trim_a,
  output logic [dax_pkg::TRIM_W-1:0]       o_ref_trim_b,
  output logic                             o_range_double,
  output logic                             o_input_pseudo,
  output logic                             o_code_twos,
  output logic                             o_single_sdo
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [2:0]                  cs_s;
    logic                        cs_q;
    logic [2:0]                  ack_s;
    logic                        ack_q;
    logic                        req;
    logic                        sent;
    logic                        sample;
    logic                        ready;
    logic [dax_pkg::CFG_W-1:0]   cfg;
    logic [dax_pkg::TRIM_W-1:0]  trim_a;
    logic [dax_pkg::TRIM_W-1:0]  trim_b;
    dax_pkg::dax_setup_type      setup;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
    logic [DEPTH-1:0][2*DW-1:0]  mem;
  } dax_sys_type;

  typedef struct packed {
    logic [dax_pkg::CNT_W-1:0]   cnt;
    logic [15:0]                 cmd;
    logic                        ok;
    logic [2:0]                  req_s;
    logic                        req_q;
    logic                        ack;
    logic [2*DW-1:0]             res;
    dax_pkg::dax_setup_type      setup;
    logic                        serial_out_a;
    logic                        serial_out_b;
  } dax_link_type;

  typedef struct packed {
    logic                        open;
    logic                        oe_a_n;
    logic                        oe_b_n;
  } dax_frame_type;

  dax_sys_type                 sy_ff;
  dax_sys_type                 nxt_sy;
  dax_link_type                lk_ff;
  dax_link_type                nxt_lk;
  dax_frame_type               fr_ff;
  dax_frame_type               nxt_fr;
  dax_pkg::dax_setup_type      st;
  logic [dax_pkg::CNT_W-1:0]   k;
  logic [3:0]                  hi;
  logic [3:0]                  ri;
  logic [2*DW-1:0]             head;
  logic [DW-1:0]               fa;
  logic [DW-1:0]               fb;
  logic                        rise;
  logic                        fall;
  logic                        push;
  logic                        pop;

  // output coding of one straight-binary core result
  function automatic logic [DW-1:0] fmt(input logic [DW-1:0] raw, input logic twos);
    if (!twos)
      fmt = raw;
    else if (raw == DW'(dax_pkg::ZERO_CODE))
      fmt = DW'(dax_pkg::NEG_FS);
    else if (raw == DW'(dax_pkg::FULL_CODE))
      fmt = DW'(dax_pkg::POS_FS);
    else
      fmt = raw - DW'(dax_pkg::MID_CODE); // mid-scale lands on zero
  endfunction

  assign head = sy_ff.mem[sy_ff.rp];
  assign fa   = fmt(i_conv_a, sy_ff.cfg[dax_pkg::CODE_FORMAT_POS]);
  assign fb   = fmt(i_conv_b, sy_ff.cfg[dax_pkg::CODE_FORMAT_POS]);
  assign push = i_conv_valid & sy_ff.ready;
  assign pop  = sy_ff.sent & (sy_ff.ack_q == sy_ff.req);

  // system side: frame edges, register updates, buffer and handshake
  always_comb
  begin
    nxt_sy = sy_ff;
    nxt_sy.cs_s  = {sy_ff.cs_s[1:0], i_cs_n};
    nxt_sy.ack_s = {sy_ff.ack_s[1:0], lk_ff.ack};
    if (sy_ff.cs_s[1] == sy_ff.cs_s[2])
      nxt_sy.cs_q = sy_ff.cs_s[2];
    if (sy_ff.ack_s[1] == sy_ff.ack_s[2])
      nxt_sy.ack_q = sy_ff.ack_s[2];
    rise = nxt_sy.cs_q & ~sy_ff.cs_q;
    fall = ~nxt_sy.cs_q & sy_ff.cs_q;
    // one strobe samples both channels at once
    nxt_sy.sample = fall;
    // link side is frozen once chip select is high, so its word is stable
    if (rise)
    begin
      nxt_sy.setup.rb_en = 1'b0;
      if (lk_ff.ok)
      begin
        case (lk_ff.cmd[15:12])
          dax_pkg::CMD_WR_CFG:
            nxt_sy.cfg = lk_ff.cmd[11:0];
          dax_pkg::CMD_WR_TRIM_A:
            nxt_sy.trim_a = lk_ff.cmd[11:3];
          dax_pkg::CMD_WR_TRIM_B:
            nxt_sy.trim_b = lk_ff.cmd[11:3];
          dax_pkg::CMD_RD_TRIM_A:
          begin
            nxt_sy.setup.rb_en   = 1'b1;
            nxt_sy.setup.rb_word = {dax_pkg::CMD_RD_TRIM_A, sy_ff.trim_a, 3'h0};
          end
          dax_pkg::CMD_RD_TRIM_B:
          begin
            nxt_sy.setup.rb_en   = 1'b1;
            nxt_sy.setup.rb_word = {dax_pkg::CMD_RD_TRIM_B, sy_ff.trim_b, 3'h0};
          end
          dax_pkg::CMD_RD_CFG:
          begin
            nxt_sy.setup.rb_en   = 1'b1;
            nxt_sy.setup.rb_word = {dax_pkg::CMD_RD_CFG, sy_ff.cfg};
          end
          default:
            nxt_sy.setup.rb_en = 1'b0;
        endcase
      end
      nxt_sy.setup.single = nxt_sy.cfg[dax_pkg::MODE_SINGLE_POS];
      nxt_sy.setup.nedges = nxt_sy.setup.single ? dax_pkg::EDGES_SINGLE : dax_pkg::EDGES_DUAL;
    end
    // head handed over by toggle; popped once the link echoes it
    if (pop)
    begin
      nxt_sy.sent = 1'b0;
      nxt_sy.rp   = (sy_ff.rp == PW'(DEPTH - 1)) ? '0 : PW'(sy_ff.rp + 1'b1);
    end
    else if (!sy_ff.sent && sy_ff.cnt != '0)
    begin
      nxt_sy.req  = ~sy_ff.req;
      nxt_sy.sent = 1'b1;
    end
    if (push)
    begin
      nxt_sy.mem[sy_ff.wp] = {fa, fb};
      nxt_sy.wp = (sy_ff.wp == PW'(DEPTH - 1)) ? '0 : PW'(sy_ff.wp + 1'b1);
    end
    nxt_sy.cnt   = (PW+1)'(sy_ff.cnt + push - pop);
    // full buffer stalls the cores rather than dropping a pair
    nxt_sy.ready = (nxt_sy.cnt < (PW+1)'(DEPTH));
  end

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      sy_ff              <= '0;
      sy_ff.cs_s         <= 3'h7;
      sy_ff.cs_q         <= 1'b1;
      sy_ff.ready        <= 1'b1;
      sy_ff.cfg          <= dax_pkg::CFG_RST;
      sy_ff.trim_a       <= dax_pkg::TRIM_RST;
      sy_ff.trim_b       <= dax_pkg::TRIM_RST;
      sy_ff.setup.nedges <= dax_pkg::EDGES_DUAL;
    end
    else
      sy_ff <= nxt_sy;
  end

  // link side: each link clock rising edge is one serial falling edge
  always_comb
  begin
    nxt_lk = lk_ff;
    nxt_fr = fr_ff;
    st = fr_ff.open ? lk_ff.setup : sy_ff.setup;
    if (!fr_ff.open)
      k = 6'h01;
    else if (lk_ff.cnt == 6'h3F)
      k = lk_ff.cnt;
    else
      k = lk_ff.cnt + 6'h01;
    hi = ~k[3:0];
    ri = 4'(6'h10 - k);
    nxt_fr.open   = 1'b1;
    nxt_fr.oe_a_n = 1'b0;
    nxt_fr.oe_b_n = st.single;
    nxt_lk.setup  = st;
    nxt_lk.cnt    = k;
    nxt_lk.req_s  = {lk_ff.req_s[1:0], sy_ff.req};
    if (lk_ff.req_s[1] == lk_ff.req_s[2])
      nxt_lk.req_q = lk_ff.req_s[2];
    if (k <= dax_pkg::CMD_EDGES)
      nxt_lk.cmd = {lk_ff.cmd[14:0], i_serial_cmd_in};
    // result pair must be in hand before the msb edge
    if (k == dax_pkg::TAKE_EDGE)
    begin
      if (lk_ff.req_q != lk_ff.ack)
      begin
        nxt_lk.res = head;
        nxt_lk.ack = lk_ff.req_q;
      end
      else
        nxt_lk.res = '0;
    end
    nxt_lk.ok    = (k >= st.nedges);
    nxt_lk.serial_out_a = 1'b0;
    nxt_lk.serial_out_b = 1'b0;
    if (st.rb_en)
    begin
      if (k <= dax_pkg::CMD_EDGES)
        nxt_lk.serial_out_a = st.rb_word[ri];
    end
    else if (k >= dax_pkg::MSB_EDGE && k < dax_pkg::EDGES_DUAL)
    begin
      nxt_lk.serial_out_a = lk_ff.res[DW + 32'(hi)];
      nxt_lk.serial_out_b = st.single ? 1'b0 : lk_ff.res[hi];
    end
    else if (st.single && k >= dax_pkg::EDGES_DUAL && k < dax_pkg::EDGES_SINGLE)
      nxt_lk.serial_out_a = lk_ff.res[hi];
  end

  // link clock may stop at any time, so its reset cannot wait for an edge
  always_ff @(posedge i_link_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      lk_ff <= '0;
    else
      lk_ff <= nxt_lk;
  end

  // frame flags end with chip select itself
  always_ff @(posedge i_link_clk or posedge i_sys_rst or posedge i_cs_n)
  begin
    if (i_sys_rst || i_cs_n)
      fr_ff <= 3'h3;
    else
      fr_ff <= nxt_fr;
  end

  assign o_serial_out_a      = lk_ff.serial_out_a;
  assign o_serial_out_b      = lk_ff.serial_out_b;
  assign o_serial_out_a_oe_n = fr_ff.oe_a_n;
  assign o_serial_out_b_oe_n = fr_ff.oe_b_n;
  assign o_sample            = sy_ff.sample;
  assign o_conv_ready        = sy_ff.ready;
  // internal reference powers up and feeds both trims only when selected
  assign o_int_ref_on   = sy_ff.cfg[dax_pkg::REF_SOURCE_POS];
  assign o_ref_trim_a   = sy_ff.trim_a;
  assign o_ref_trim_b   = sy_ff.trim_b;
  assign o_range_double = sy_ff.cfg[dax_pkg::RANGE_DOUBLE_POS];
  assign o_input_pseudo = sy_ff.cfg[dax_pkg::INPUT_TYPE_POS];
  assign o_code_twos    = sy_ff.cfg[dax_pkg::CODE_FORMAT_POS];
  assign o_single_sdo   = sy_ff.cfg[dax_pkg::MODE_SINGLE_POS];

  // checks on the system side
  property p_ref_write;
    @(posedge i_clock) disable iff (i_sys_rst)
    $rose(sy_ff.cs_q) && lk_ff.ok && lk_ff.cmd[15:12] == dax_pkg::CMD_WR_CFG
      |-> o_int_ref_on == lk_ff.cmd[6] ##1 o_int_ref_on == $past(lk_ff.cmd[6], 2);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("ref bit not applied");
  property p_trim_a;
    @(posedge i_clock) disable iff (i_sys_rst)
    $rose(sy_ff.cs_q) && lk_ff.ok && lk_ff.cmd[15:12] == dax_pkg::CMD_WR_TRIM_A
      |-> o_ref_trim_a == lk_ff.cmd[11:3] && o_ref_trim_b == $past(o_ref_trim_b);
  endproperty
  a_trim_a: assert property (p_trim_a) else $error("trim a write wrong");
  property p_trim_b;
    @(posedge i_clock) disable iff (i_sys_rst)
    $rose(sy_ff.cs_q) && lk_ff.ok && lk_ff.cmd[15:12] == dax_pkg::CMD_WR_TRIM_B
      |-> o_ref_trim_b == lk_ff.cmd[11:3] && $stable(o_ref_trim_a);
  endproperty
  a_trim_b: assert property (p_trim_b) else $error("trim b write wrong");
  property p_range;
    @(posedge i_clock) disable iff (i_sys_rst)
    $rose(sy_ff.cs_q) && lk_ff.ok && lk_ff.cmd[15:12] == dax_pkg::CMD_WR_CFG
      |-> o_range_double == lk_ff.cmd[9] && o_input_pseudo == lk_ff.cmd[7];
  endproperty
  a_range: assert property (p_range) else $error("range or input type wrong");
  property p_binary;
    @(posedge i_clock) disable iff (i_sys_rst)
    !o_code_twos |-> fa == i_conv_a && fb == i_conv_b;
  endproperty
  a_binary: assert property (p_binary) else $error("straight binary altered");
  property p_twos;
    @(posedge i_clock) disable iff (i_sys_rst)
    o_code_twos && i_conv_a == dax_pkg::MID_CODE |-> fa == dax_pkg::TC_MIDSCALE;
  endproperty
  a_twos: assert property (p_twos) else $error("twos mid-scale wrong");
  property p_short_frame;
    @(posedge i_clock) disable iff (i_sys_rst)
    $rose(sy_ff.cs_q) && !lk_ff.ok |-> $stable(sy_ff.cfg) && $stable(o_ref_trim_a)
      && $stable(o_ref_trim_b) && !sy_ff.setup.rb_en;
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("short frame wrote");
  property p_sample;
    @(posedge i_clock) disable iff (i_sys_rst)
    $fell(sy_ff.cs_q) |-> o_sample ##1 !o_sample;
  endproperty
  a_sample: assert property (p_sample) else $error("sample strobe wrong");
  property p_readback;
    @(posedge i_clock) disable iff (i_sys_rst)
    $rose(sy_ff.cs_q) && lk_ff.ok && lk_ff.cmd[15:12] == dax_pkg::CMD_RD_CFG
      |-> sy_ff.setup.rb_en && sy_ff.setup.rb_word == {dax_pkg::CMD_RD_CFG, $past(sy_ff.cfg)};
  endproperty
  a_readback: assert property (p_readback) else $error("readback not armed");
  c_cfg_write: cover property (@(posedge i_clock) $rose(sy_ff.cs_q) && lk_ff.ok
    && lk_ff.cmd[15:12] == dax_pkg::CMD_WR_CFG);
  c_readback: cover property (@(posedge i_clock) $rose(sy_ff.setup.rb_en));
  c_full: cover property (@(posedge i_clock) !sy_ff.ready);
endmodule

// ---- bench/dax_host.sv ----
// host side model: drives framed serial link and records both data lines.
// assumes the link clock stands still and low outside frames.
`timescale 1ns/1ps
module dax_host #(
  // link half period in ns; keep 2*HALF at 50 ns or more on real parts
  parameter int HALF = 3
) (
  // serial link toward the device
  output logic       o_link_clk,
  output logic       o_cs_n,
  output logic       o_cmd,
  // data lines back from the device
  input  wire logic  i_serial_out_a,
  input  wire logic  i_serial_out_a_oe_n,
  input  wire logic  i_serial_out_b,
  input  wire logic  i_serial_out_b_oe_n
);
  logic [63:0] cap_a;
  logic [63:0] cap_b;

  // idle link: clock parked, select high, command low
  // never enters deep power-down, so no wake-up wait is owed here
  initial
  begin
    o_link_clk = 1'b0;
    o_cs_n     = 1'b1;
    o_cmd      = 1'b0;
  end

  // one frame of n edges; released lines are recorded as unknown
  task automatic frame(input logic [15:0] cmd, input int n);
    cap_a  = 64'h0;
    cap_b  = 64'h0;
    o_cs_n = 1'b0;
    #(2*HALF);
    for (int k = 1; k <= n; k++)
    begin
      o_cmd = (k <= 16) ? cmd[16-k] : ~o_cmd; // msb first, then a toggling filler
      #HALF o_link_clk = 1'b1;
      #HALF o_link_clk = 1'b0;
      cap_a = {cap_a[62:0], i_serial_out_a_oe_n ? 1'bx : i_serial_out_a};
      cap_b = {cap_b[62:0], i_serial_out_b_oe_n ? 1'bx : i_serial_out_b};
    end
    #HALF o_cs_n = 1'b1; // ends frame after the chosen edge count
    o_cmd = 1'b0;
  endtask
endmodule

// ---- bench/dual_adc_config_and_coding_tb.sv ----
// self-checking bench: queue model of config state and result pairs.
// assumes the host model in dax_host and the package dax_pkg.
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("wrong value at %0t got %h exp %h", $time, g, e); \
    end \
  end
module dual_adc_config_and_coding_tb;
  logic i_clock, i_sys_rst, lclk, cs_n, cmd, sa, sa_oe_n, sb, sb_oe_n;
  logic o_sample, i_conv_valid, o_conv_ready, ref_on, rng, pseudo, twos, single;
  logic [15:0] i_conv_a, i_conv_b, rb_w;
  logic [8:0]  trim_a, trim_b, ta, tb;
  logic [11:0] cfg_m;
  logic [15:0] qa[$];
  logic [15:0] qb[$];
  logic [3:0]  nops[10] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  logic        rb_on;
  int fails, compares, samples, frames, refused;
  int seed = 32'h7842;

  dax_top u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_link_clk(lclk),
    .i_cs_n(cs_n), .i_serial_cmd_in(cmd), .o_serial_out_a(sa),
    .o_serial_out_a_oe_n(sa_oe_n), .o_serial_out_b(sb), .o_serial_out_b_oe_n(sb_oe_n),
    .o_sample(o_sample), .i_conv_valid(i_conv_valid), .i_conv_a(i_conv_a),
    .i_conv_b(i_conv_b), .o_conv_ready(o_conv_ready), .o_int_ref_on(ref_on),
    .o_ref_trim_a(trim_a), .o_ref_trim_b(trim_b), .o_range_double(rng),
    .o_input_pseudo(pseudo), .o_code_twos(twos), .o_single_sdo(single));
  dax_host u_host (.o_link_clk(lclk), .o_cs_n(cs_n), .o_cmd(cmd), .i_serial_out_a(sa),
    .i_serial_out_a_oe_n(sa_oe_n), .i_serial_out_b(sb), .i_serial_out_b_oe_n(sb_oe_n));

  // 100 MHz system clock
  always #5 i_clock = ~i_clock;

  // count sample pulses, one expected per frame
  always @(posedge i_clock)
    if (o_sample === 1'b1)
      samples++;

  // coding applied to a raw straight-binary pair at push time
  function automatic logic [15:0] fmt(input logic [15:0] r);
    if (!cfg_m[4]) return r;
    if (r == 16'h0000) return 16'h8000;
    if (r == 16'hFFFF) return 16'h7FFF;
    return r - 16'h7FFF;
  endfunction

  task automatic close_out();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // offer a pair to the buffer; a refused offer is simply not queued
  task automatic push(input logic [15:0] a, input logic [15:0] b);
    @(negedge i_clock);
    i_conv_valid = 1'b1;
    i_conv_a = a;
    i_conv_b = b;
    if (o_conv_ready === 1'b1)
    begin
      qa.push_back(fmt(a));
      qb.push_back(fmt(b));
    end
    else
      refused++;
    @(negedge i_clock);
    i_conv_valid = 1'b0;
  endtask

  // one frame: predict serial words, run it, update state, compare all
  task automatic xfer(input logic [15:0] c, input int n);
    logic [63:0] ea, eb;
    logic [15:0] pa, pb;
    int need;
    need = cfg_m[10] ? 48 : 32;
    pa = 16'h0;
    pb = 16'h0;
    ea = {rb_w, 48'h0};
    eb = 64'h0;
    if (!rb_on)
    begin
      if (qa.size() > 0)
      begin
        pa = qa.pop_front();
        pb = qb.pop_front();
      end
      ea = cfg_m[10] ? {15'h0, pa, pb, 1'b0, 16'h0} : {15'h0, pa, 1'b0, 32'h0};
      eb = cfg_m[10] ? {{48{1'bx}}, 16'h0} : {15'h0, pb, 1'b0, 32'h0};
    end
    rb_on = 1'b0;
    u_host.frame(c, n);
    #1;
    `CHK({sa_oe_n, sb_oe_n}, 2'b11) // released as soon as select rises
    frames++;
    if (n >= need)
    begin
      rb_on = (c[15:12] >= 4'h1 && c[15:12] <= 4'h3);
      rb_w = (c[15:12] == 4'h3) ? {4'h3, cfg_m} :
             {c[15:12], (c[15:12] == 4'h1) ? ta : tb, 3'b000};
      case (c[15:12])
        dax_pkg::CMD_WR_CFG:    cfg_m = c[11:0];
        dax_pkg::CMD_WR_TRIM_A: ta = c[11:3];
        dax_pkg::CMD_WR_TRIM_B: tb = c[11:3];
        default: ;
      endcase
    end
    repeat (10) @(posedge i_clock);
    `CHK(u_host.cap_a << (64 - n), ea)
    `CHK(u_host.cap_b << (64 - n), eb)
    `CHK({single, rng, pseudo, ref_on, twos}, {cfg_m[10:9], cfg_m[7:6], cfg_m[4]})
    `CHK({trim_a, trim_b}, {ta, tb})
    `CHK(samples, frames)
  endtask

  // stop a hung run
  initial
  begin
    repeat (20000) @(posedge i_clock);
    fails++;
    close_out();
  end

  // main sequence
  initial
  begin
    {i_clock, i_conv_valid, rb_on, fails, compares, samples, frames, refused} = '0;
    {i_conv_a, i_conv_b, cfg_m, rb_w} = '0;
    ta = 9'h1FF;
    tb = 9'h1FF;
    i_sys_rst = 1'b1;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    i_sys_rst = 1'b0;
    `CHK(o_conv_ready, 1'b1) // reset state
    xfer(16'h0000, 32);
    push($random(seed), $random(seed));
    xfer(16'h0000, 32);
    xfer({dax_pkg::CMD_WR_CFG, 12'h0D0}, 32);
    push(16'h0000, 16'hFFFF);
    push(16'h7FFF, 16'h8000);
    push(16'hFFFF, 16'h0000);
    push($random(seed), $random(seed));
    `CHK(refused > 0, 1'b1) // full buffer refuses
    repeat (4) xfer(16'h0000, 32);
    `CHK(o_conv_ready, 1'b1) // drained
    xfer({dax_pkg::CMD_WR_CFG, 12'h200}, 31);
    xfer({dax_pkg::CMD_WR_CFG, 12'h200}, 32);
    foreach (nops[i]) xfer({nops[i], 12'hFFF}, 32);
    xfer({dax_pkg::CMD_WR_TRIM_A, 9'h0A5, 3'b000}, 32);
    xfer({dax_pkg::CMD_WR_TRIM_B, 9'h15A, 3'b000}, 32);
    for (int c = 1; c <= 3; c++)
    begin
      xfer({c[3:0], 12'h000}, 32);
      xfer(16'h0000, 32);
    end
    xfer({dax_pkg::CMD_WR_CFG, 12'h400}, 32);
    push($random(seed), $random(seed));
    xfer(16'h0000, 48);
    xfer({dax_pkg::CMD_WR_CFG, 12'h4D0}, 47);
    xfer({dax_pkg::CMD_WR_CFG, 12'h4D0}, 48);
    push($random(seed), 16'hFFFF);
    xfer(16'h0000, 48);
    close_out();
  end
endmodule
